// ===== design/kpi_pkg.sv
// package: register map, field positions and reset values of the keypad interrupt block
package kpi_pkg;
    // register word addresses (byte address / 4)
    localparam int KPI_ADDR_W = 2;
    localparam logic [1:0] KPI_STATUS_CONTROL_ADDR = 2'h0;
    localparam logic [1:0] KPI_PIN_ENABLES_ADDR = 2'h1;
    localparam logic [1:0] KPI_POLARITY_SELECT_ADDR = 2'h2;
    // status and control field positions
    localparam int KPI_DETECT_FLAG_BIT = 3;
    localparam int KPI_FLAG_ACK_BIT = 2;
    localparam int KPI_IRQ_MASK_BIT = 1;
    localparam int KPI_MODE_BIT = 0;
    // implemented input positions 5,4,2,1,0
    localparam logic [7:0] KPI_PIN_MASK = 8'h37;
    localparam int KPI_NUM_INPUTS = 8;
    // reset values
    localparam logic [7:0] KPI_REG_RESET = 8'h00;
    // answer to unmapped addresses
    localparam logic [31:0] KPI_UNMAPPED_DATA = 32'h0000_0000;
    // bus-side enums
    typedef enum logic [1:0] {
        KPI_BUS_IDLE = 2'b01,
        KPI_BUS_DONE = 2'b10
    } kpi_bus_state_type;
endpackage

// ===== design/kpi_input_sync.sv
// two-flop synchroniser for the keypad input pins
`timescale 1ns/1ps
module kpi_input_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // only the second flop is visible outside; reset to the idle-high pin
    // level so no false edge follows reset
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule // kpi_input_sync

// ===== design/kpi_keypad_interrupt_block.sv
// keypad pin interrupt block with avalon-mm register slave
`timescale 1ns/1ps
module kpi_keypad_interrupt_block
    import kpi_pkg::*;
#(
    parameter int NUM_INPUTS = kpi_pkg::KPI_NUM_INPUTS
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // avalon-mm slave
    input wire logic [kpi_pkg::KPI_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    // keypad pins
    input wire logic [NUM_INPUTS-1:0] i_keypad_input_n,
    // low-power state of the processor
    input wire logic i_stop_mode,
    // interrupt request and wake
    output logic o_irq,
    output logic o_wakeup
);
    import kpi_pkg::*;

    initial begin
        if (NUM_INPUTS != KPI_NUM_INPUTS) begin
            $error("kpi: NUM_INPUTS must be 8");
        end
    end

    // registers
    logic [7:0] pin_enables_reg;
    logic [7:0] polarity_select_reg;
    logic irq_mask_enable_reg;
    logic edge_level_mode_reg;
    logic detect_flag_reg;
    logic detect_flag_next;
    logic [7:0] prev_sample_reg;
    logic [31:0] readdata_reg;
    kpi_bus_state_type bus_state_reg;

    logic [7:0] sample;
    logic [7:0] asserted_now;
    logic [7:0] asserted_prev;
    logic [7:0] edge_hit;
    logic [7:0] level_hit;
    logic [7:0] live_enables;
    logic detect;
    logic any_asserted;
    logic wr_take;
    logic rd_take;
    logic ack_write;
    logic [1:0] be_ok;
    logic [7:0] sc_read;

    // pins cross into the bus clock domain before the flag decision; the stop-mode wake path reads the raw pins
    kpi_input_sync #(
        .WIDTH(NUM_INPUTS)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_async(i_keypad_input_n),
        .o_sync(sample)
    );

    // only implemented positions ever count
    assign live_enables = pin_enables_reg & KPI_PIN_MASK;

    // per-input detection; polarity 1 means active high
    genvar g;
    generate
        for (g = 0; g < KPI_NUM_INPUTS; g++) begin : g_detect
            assign asserted_now[g] = sample[g] ~^ polarity_select_reg[g];
            assign asserted_prev[g] = prev_sample_reg[g] ~^ polarity_select_reg[g];
            // deasserted on one cycle, asserted on the next
            assign edge_hit[g] = live_enables[g] & asserted_now[g] & ~asserted_prev[g];
            assign level_hit[g] = live_enables[g] & edge_level_mode_reg & asserted_now[g];
        end
    endgenerate

    assign detect = |edge_hit | |level_hit;
    assign any_asserted = |(live_enables & asserted_now);

    // previous sample, seeded to the deasserted level of all-high pins
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            prev_sample_reg <= 8'hFF;
        end else begin
            prev_sample_reg <= sample;
        end
    end

    // bus handshake: one wait cycle, then answer; a write lands only on the
    // edge where waitrequest is seen low, reads are fetched a cycle early
    assign wr_take = i_avs_write & (bus_state_reg == KPI_BUS_DONE);
    assign rd_take = i_avs_read & (bus_state_reg == KPI_BUS_IDLE);
    assign be_ok = {1'b0, i_avs_byteenable[0]};
    assign ack_write = wr_take & be_ok[0] & (i_avs_address == KPI_STATUS_CONTROL_ADDR)
        & i_avs_writedata[KPI_FLAG_ACK_BIT];

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            bus_state_reg <= KPI_BUS_IDLE;
        end else begin
            unique case (bus_state_reg)
                KPI_BUS_IDLE: begin
                    if (i_avs_read | i_avs_write) begin
                        bus_state_reg <= KPI_BUS_DONE;
                    end
                end
                KPI_BUS_DONE: begin
                    bus_state_reg <= KPI_BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= KPI_BUS_IDLE;
                end
            endcase
        end
    end

    // waitrequest drops in the answer cycle only
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & (bus_state_reg != KPI_BUS_DONE);
    assign o_avs_response = 2'b00;
    assign o_avs_readdata = readdata_reg;

    // control register writes; ack and flag positions are not storage
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pin_enables_reg <= KPI_REG_RESET;
            polarity_select_reg <= KPI_REG_RESET;
            irq_mask_enable_reg <= 1'b0;
            edge_level_mode_reg <= 1'b0;
        end else if (wr_take & be_ok[0]) begin
            unique case (i_avs_address)
                KPI_STATUS_CONTROL_ADDR: begin
                    irq_mask_enable_reg <= i_avs_writedata[KPI_IRQ_MASK_BIT];
                    edge_level_mode_reg <= i_avs_writedata[KPI_MODE_BIT];
                end
                KPI_PIN_ENABLES_ADDR: begin
                    pin_enables_reg <= i_avs_writedata[7:0] & KPI_PIN_MASK;
                end
                KPI_POLARITY_SELECT_ADDR: begin
                    polarity_select_reg <= i_avs_writedata[7:0] & KPI_PIN_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // flag: detection always wins over acknowledge
    always_comb begin
        detect_flag_next = detect_flag_reg;
        if (ack_write & ~(edge_level_mode_reg & any_asserted)) begin
            detect_flag_next = 1'b0;
        end
        if (detect) begin
            detect_flag_next = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            detect_flag_reg <= 1'b0;
        end else begin
            detect_flag_reg <= detect_flag_next;
        end
    end

    // read mux; unimplemented bits read zero
    always_comb begin
        sc_read = 8'h00;
        sc_read[KPI_DETECT_FLAG_BIT] = detect_flag_reg;
        sc_read[KPI_IRQ_MASK_BIT] = irq_mask_enable_reg;
        sc_read[KPI_MODE_BIT] = edge_level_mode_reg;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            readdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            unique case (i_avs_address)
                KPI_STATUS_CONTROL_ADDR: readdata_reg <= {24'h000000, sc_read};
                KPI_PIN_ENABLES_ADDR: readdata_reg <= {24'h000000, pin_enables_reg};
                KPI_POLARITY_SELECT_ADDR: readdata_reg <= {24'h000000, polarity_select_reg};
                default: readdata_reg <= KPI_UNMAPPED_DATA;
            endcase
        end
    end

    // request toward the processor
    assign o_irq = detect_flag_reg & irq_mask_enable_reg;
    // wake: clocked path in wait, raw pin path in stop since the clock is gone
    assign o_wakeup = irq_mask_enable_reg & (detect_flag_reg
        | (i_stop_mode & |(live_enables & ~(i_keypad_input_n ^ polarity_select_reg))));
endmodule // kpi_keypad_interrupt_block

// ===== testbench/kpi_checker_properties.sv
// checker: bus and interrupt port properties of the keypad block
`timescale 1ns/1ps
module kpi_checker
    import kpi_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [kpi_pkg::KPI_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] o_avs_response,
    input wire logic i_stop_mode,
    input wire logic o_irq,
    input wire logic o_wakeup
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // bits that may read as one at each address
    wire logic [7:0] live = (i_avs_address == 2'h0) ? 8'h0B :
        (i_avs_address == 2'h3) ? 8'h00 : 8'h37;
    a_resp_okay: assert property (o_avs_response == 2'h0)
        else $error("bad response");
    a_wait_once: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("wait not one cycle");
    a_rd_fields: assert property (i_avs_read && !o_avs_waitrequest
        |-> (o_avs_readdata & ~{24'h0, live}) == 32'h0) else $error("bad read bits");
    a_irq_read: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 2'h0
        |-> (o_avs_readdata[3] && o_avs_readdata[1]) == $past(o_irq)) else $error("irq mismatch");
    a_irq_wake: assert property (o_irq |-> o_wakeup)
        else $error("irq without wake");
    a_run_wake: assert property (!i_stop_mode |-> o_wakeup == o_irq)
        else $error("wake differs in run");
    a_irq_fall: assert property ($fell(o_irq)
        |-> $past(i_avs_write) && $past(i_avs_address) == 2'h0) else $error("irq fell alone");
    a_reset_idle: assert property (disable iff (1'b0) !i_rst_n
        |=> !o_irq && !o_wakeup) else $error("busy after reset");
    c_irq: cover property ($rose(o_irq));
    c_ack: cover property ($fell(o_irq));
    c_stop: cover property (i_stop_mode && o_wakeup);
endmodule // kpi_checker

bind kpi_keypad_interrupt_block kpi_checker u_chk (.i_mclk, .i_rst_n, .i_avs_address,
    .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_avs_response,
    .i_stop_mode, .o_irq, .o_wakeup);

// ===== testbench/kpi_keypad_model.sv
// keypad switch model: bonded pins 5,4,2,1,0 follow the levels the bench commands
`timescale 1ns/1ps
module kpi_keypad_model (
    input wire logic i_mclk,
    input wire logic [7:0] i_level,
    output logic [7:0] o_keypad_input_n
);
    logic spare_reg = 1'b0;
    // unbonded positions toggle so a leak past the enables shows up
    always_ff @(posedge i_mclk) begin
        spare_reg <= !spare_reg;
        o_keypad_input_n <= {{2{spare_reg}}, i_level[5:4], spare_reg, i_level[2:0]};
    end
endmodule // kpi_keypad_model

// ===== testbench/tb_top.sv
// self-checking bench for the keypad interrupt block
`timescale 1ns/1ps
module tb_top;
    import kpi_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] adr = 2'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wreq, irq, wake;
    logic stop = 1'b0;
    logic [7:0] lvl = 8'hFF;
    logic [7:0] pins, got;
    int bad_count = 0;
    int n_checks = 0;
    // rows: address, write value, expected read back
    localparam logic [19:0] ROWS [7] = '{20'h0FF03, 20'h00800, 20'h1FF37,
        20'h2FF37, 20'h3FF00, 20'h10000, 20'h20000};
    always #20 clk = ~clk;
    kpi_keypad_model u_keys (.i_mclk(clk), .i_level(lvl), .o_keypad_input_n(pins));
    kpi_keypad_interrupt_block dut (.i_mclk(clk), .i_rst_n(rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_avs_response(),
        .i_keypad_input_n(pins), .i_stop_mode(stop), .o_irq(irq), .o_wakeup(wake));
    task automatic results;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_reg({7'h0, g}, {7'h0, e});
    endtask
    // one transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        // waitrequest is combinational: look at it mid-cycle, once settled
        do begin
            @(negedge clk);
            k++;
        end while (wreq !== 1'b0 && k < 20);
        got = rdat[7:0];
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge clk);
        if (k == 20) begin
            bad_count++;
            results();
        end
    endtask
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, i[1:0], 8'h00);
            chk_reg(got, KPI_REG_RESET);
        end
        foreach (ROWS[i]) begin
            bus(1'b1, ROWS[i][17:16], ROWS[i][15:8]);
            bus(1'b0, ROWS[i][17:16], 8'h00);
            chk_reg(got, ROWS[i][7:0]);
        end
        // edge only, falling, pin 0 enabled; pin 1 moves while disabled
        bus(1'b1, 2'h1, 8'h01);
        bus(1'b1, 2'h0, 8'h04);
        lvl <= 8'hFD;
        settle();
        bus(1'b0, 2'h0, 8'h00);
        chk_reg(got, 8'h00);
        lvl <= 8'hFC;
        settle();
        bus(1'b0, 2'h0, 8'h00);
        chk_reg(got, 8'h08);
        chk_bit(irq, 1'b0);
        bus(1'b1, 2'h0, 8'h02);
        chk_bit(irq, 1'b1);
        bus(1'b1, 2'h0, 8'h06);
        chk_bit(irq, 1'b0);
        // edge and level, rising on pin 2
        lvl <= 8'hF8;
        bus(1'b1, 2'h2, 8'h04);
        bus(1'b1, 2'h1, 8'h04);
        bus(1'b1, 2'h0, 8'h07);
        chk_bit(irq, 1'b0);
        lvl <= 8'hFC;
        settle();
        chk_bit(irq, 1'b1);
        bus(1'b1, 2'h0, 8'h07);
        bus(1'b0, 2'h0, 8'h00);
        chk_reg(got, 8'h0B);
        lvl <= 8'hF8;
        settle();
        bus(1'b1, 2'h0, 8'h07);
        bus(1'b0, 2'h0, 8'h00);
        chk_reg(got, 8'h03);
        // stop: raw pin wakes before the flag path can react
        stop <= 1'b1;
        lvl <= 8'hFC;
        repeat (2) @(posedge clk);
        chk_bit(wake, 1'b1);
        results();
    end
endmodule // tb_top
